// ==== design/twsm_monitor.sv ====
// trigger wait tracking, overtrigger detection, output line routing and AHB-Lite registers
`default_nettype none

module twsm_monitor
  import twsm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // hardware triggers and re-entry pulses from the acquisition engine
  input  wire logic        ext_acq_start_trigger_in,
  input  wire logic        ext_frame_start_trigger_in,
  input  wire logic        ext_line_start_trigger_in,
  input  wire logic        acq_ready_in,
  input  wire logic        frame_ready_in,
  input  wire logic        line_ready_in,
  // wait outputs, routed lines, accepted starts, events
  output logic             acq_start_wait_out,
  output logic             frame_start_wait_out,
  output logic             line_start_wait_out,
  output logic [1:0]       out_line,
  output logic [2:0]       start_accepted,
  output logic [2:0]       overtrigger_event,
  output logic             irq
);

  // bus state
  logic        dp_write_ff;
  logic        dp_read_ff;
  logic [7:0]  dp_addr_ff;
  logic [31:0] hrdata_ff;
  logic        hreadyout_ff;
  logic        hresp_ff;
  logic        addr_phase;
  logic        wr_en;
  logic [31:0] rd_mux;

  // control and status registers
  logic [2:0]  hw_enable_ff;
  logic [2:0]  sw_trig_ff;
  twsm_sel_t   wait_status_select_ff;
  logic        output_line_pick_ff;
  twsm_src_t   output_line_source_ff [TWSM_NUM_LINES];
  logic [2:0]  evt_status_ff;
  logic [2:0]  evt_enable_ff;
  logic [2:0]  evt_clear;
  logic        wait_status_value;

  // trigger path
  logic [2:0]  ext_in;
  logic [2:0]  ext_prev_ff;
  logic [2:0]  hw_edge;
  logic [2:0]  trig;
  logic [2:0]  accept;
  logic [2:0]  over;
  logic [2:0]  wait_ff;
  logic [2:0]  nxt_wait;
  logic [2:0]  nxt_wait_out;
  logic [2:0]  wait_out_ff;
  logic [1:0]  out_line_ff;
  logic [2:0]  start_accepted_ff;
  logic [2:0]  overtrigger_ff;
  logic        irq_ff;

  // pick the wait output that a line source code names
  function automatic logic twsm_route(input twsm_src_t src, input logic [2:0] w);
    logic r;
    r = 1'b0;
    case (src)
      TWSM_SRC_ACQ_WAIT:   r = w[TWSM_BIT_ACQ];
      TWSM_SRC_FRAME_WAIT: r = w[TWSM_BIT_FRAME];
      TWSM_SRC_LINE_WAIT:  r = w[TWSM_BIT_LINE];
      default:             r = 1'b0;
    endcase
    return r;
  endfunction : twsm_route

  // ---------------- AHB-Lite slave ----------------

  assign addr_phase = hsel & hready & htrans[1];
  assign wr_en      = dp_write_ff;

  // writes are zero-wait; reads take one wait state so that a read right
  // behind a write to the same register returns the freshly written value
  always_ff @(posedge clk) begin
    if (srst) begin
      dp_write_ff  <= 1'b0;
      dp_read_ff   <= 1'b0;
      dp_addr_ff   <= 8'h00;
      hreadyout_ff <= 1'b1;
      hrdata_ff    <= 32'h0000_0000;
      hresp_ff     <= 1'b0;
    end else begin
      dp_write_ff <= addr_phase & hwrite;
      dp_read_ff  <= addr_phase & ~hwrite;
      if (addr_phase) begin
        dp_addr_ff <= {haddr[7:2], 2'b00};
      end
      if (addr_phase && !hwrite) begin
        hreadyout_ff <= 1'b0;
      end else if (dp_read_ff) begin
        hreadyout_ff <= 1'b1;
        hrdata_ff    <= rd_mux;
      end
      hresp_ff <= 1'b0; // always OKAY
    end
  end

  // read decode; write-only and unmapped words read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (dp_addr_ff == TWSM_OFS_HW_ENABLE) begin
      rd_mux[2:0] = hw_enable_ff;
    end else if (dp_addr_ff == TWSM_OFS_STAT_SEL) begin
      rd_mux[1:0] = wait_status_select_ff;
    end else if (dp_addr_ff == TWSM_OFS_STAT_VALUE) begin
      rd_mux[0] = wait_status_value;
    end else if (dp_addr_ff == TWSM_OFS_LINE_PICK) begin
      rd_mux[0] = output_line_pick_ff;
    end else if (dp_addr_ff == TWSM_OFS_LINE_SRC) begin
      rd_mux[1:0] = output_line_source_ff[output_line_pick_ff];
    end else if (dp_addr_ff == TWSM_OFS_EVT_STATUS) begin
      rd_mux[2:0] = evt_status_ff;
    end else if (dp_addr_ff == TWSM_OFS_EVT_ENABLE) begin
      rd_mux[2:0] = evt_enable_ff;
    end else if (dp_addr_ff == TWSM_OFS_WAIT_STATE) begin
      rd_mux[2:0] = wait_ff;
    end
  end

  // status value follows the selected wait state; code 3 reads false
  always_comb begin
    case (wait_status_select_ff)
      TWSM_SEL_ACQ:   wait_status_value = wait_ff[TWSM_BIT_ACQ];
      TWSM_SEL_FRAME: wait_status_value = wait_ff[TWSM_BIT_FRAME];
      TWSM_SEL_LINE:  wait_status_value = wait_ff[TWSM_BIT_LINE];
      default:        wait_status_value = 1'b0;
    endcase
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (srst) begin
      hw_enable_ff          <= TWSM_RST_HW_ENABLE;
      wait_status_select_ff <= TWSM_RST_STAT_SEL;
      evt_enable_ff         <= TWSM_RST_EVT_EN;
    end else if (wr_en) begin
      if (dp_addr_ff == TWSM_OFS_HW_ENABLE) begin
        hw_enable_ff <= hwdata[2:0];
      end else if (dp_addr_ff == TWSM_OFS_STAT_SEL) begin
        wait_status_select_ff <= twsm_sel_t'(hwdata[1:0]);
      end else if (dp_addr_ff == TWSM_OFS_EVT_ENABLE) begin
        evt_enable_ff <= hwdata[2:0];
      end
    end
  end

  // output line routing: pick a line, then write its source
  always_ff @(posedge clk) begin
    if (srst) begin
      output_line_pick_ff      <= TWSM_RST_LINE_PICK;
      output_line_source_ff[0] <= TWSM_RST_SRC_LINE1;
      output_line_source_ff[1] <= TWSM_RST_SRC_LINE2;
    end else if (wr_en) begin
      if (dp_addr_ff == TWSM_OFS_LINE_PICK) begin
        output_line_pick_ff <= hwdata[0];
      end else if (dp_addr_ff == TWSM_OFS_LINE_SRC) begin
        output_line_source_ff[output_line_pick_ff] <= twsm_src_t'(hwdata[1:0]);
      end
    end
  end

  // software triggers and event clears are one-cycle strobes from a write
  always_ff @(posedge clk) begin
    if (srst) begin
      sw_trig_ff <= 3'h0;
    end else if (wr_en && dp_addr_ff == TWSM_OFS_SW_TRIGGER) begin
      sw_trig_ff <= hwdata[2:0];
    end else begin
      sw_trig_ff <= 3'h0;
    end
  end

  // clear strobe lives only in the write data phase, the one cycle in which hwdata stands
  assign evt_clear = (wr_en && dp_addr_ff == TWSM_OFS_EVT_CLEAR) ? hwdata[2:0] : 3'h0;

  // ---------------- trigger tracking ----------------

  assign ext_in = {ext_line_start_trigger_in, ext_frame_start_trigger_in, ext_acq_start_trigger_in};

  // rising-edge detect; inputs are already synchronous to clk
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_prev_ff <= 3'h0;
    end else begin
      ext_prev_ff <= ext_in;
    end
  end

  // a hardware trigger only counts for a type whose hardware triggering is on;
  // a software and a hardware trigger of one type in one cycle count once
  assign hw_edge = ext_in & ~ext_prev_ff & hw_enable_ff;
  assign trig    = hw_edge | sw_trig_ff;
  assign accept  = trig & wait_ff;
  assign over    = trig & ~wait_ff;

  // accept beats re-entry so a wait always drops on its trigger; an ignored
  // trigger leaves the wait state untouched
  assign nxt_wait = ~accept & (wait_ff | {line_ready_in, frame_ready_in, acq_ready_in});

  always_ff @(posedge clk) begin
    if (srst) begin
      wait_ff <= TWSM_RST_WAIT;
    end else begin
      wait_ff <= nxt_wait;
    end
  end

  // acquisition and frame waits exist only with hardware triggering;
  // the line wait is always shown
  assign nxt_wait_out = {nxt_wait[TWSM_BIT_LINE],
                         nxt_wait[TWSM_BIT_FRAME] & hw_enable_ff[TWSM_BIT_FRAME],
                         nxt_wait[TWSM_BIT_ACQ] & hw_enable_ff[TWSM_BIT_ACQ]};

  // wait outputs and routed lines, registered together so they never skew
  always_ff @(posedge clk) begin
    if (srst) begin
      wait_out_ff <= 3'h0;
      out_line_ff <= 2'h0;
    end else begin
      wait_out_ff    <= nxt_wait_out;
      out_line_ff[0] <= twsm_route(output_line_source_ff[0], nxt_wait_out);
      out_line_ff[1] <= twsm_route(output_line_source_ff[1], nxt_wait_out);
    end
  end

  // start and overtrigger pulses, one cycle per trigger
  always_ff @(posedge clk) begin
    if (srst) begin
      start_accepted_ff <= 3'h0;
      overtrigger_ff    <= 3'h0;
    end else begin
      start_accepted_ff <= accept;
      overtrigger_ff    <= over;
    end
  end

  // sticky overtrigger status; a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      evt_status_ff <= 3'h0;
      irq_ff        <= 1'b0;
    end else begin
      evt_status_ff <= (evt_status_ff & ~evt_clear) | over;
      irq_ff        <= |(((evt_status_ff & ~evt_clear) | over) & evt_enable_ff);
    end
  end

  assign hrdata               = hrdata_ff;
  assign hreadyout            = hreadyout_ff;
  assign hresp                = hresp_ff;
  assign acq_start_wait_out   = wait_out_ff[TWSM_BIT_ACQ];
  assign frame_start_wait_out = wait_out_ff[TWSM_BIT_FRAME];
  assign line_start_wait_out  = wait_out_ff[TWSM_BIT_LINE];
  assign out_line             = out_line_ff;
  assign start_accepted       = start_accepted_ff;
  assign overtrigger_event    = overtrigger_ff;
  assign irq                  = irq_ff;

  // ---------------- assertions ----------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_sw_acq_drop: assert property (sw_trig_ff[0] && !wait_ff[0] |=> overtrigger_event[0] && !start_accepted[0])
    else $error("ignored sw acquisition trigger gave no event");
  a_sw_frame_drop: assert property (sw_trig_ff[1] && !wait_ff[1] |=> overtrigger_event[1] && !start_accepted[1])
    else $error("ignored sw frame trigger gave no event");
  a_sw_line_drop: assert property (sw_trig_ff[2] && !wait_ff[2] |=> overtrigger_event[2] && !start_accepted[2])
    else $error("ignored sw line trigger gave no event");
  a_hw_acq_drop: assert property (hw_edge[0] && !wait_ff[0] && !acq_ready_in |=> overtrigger_event[0] && !wait_ff[0])
    else $error("ignored hw acquisition trigger changed state");
  a_hw_frame_drop: assert property (hw_edge[1] && !wait_ff[1] |=> overtrigger_event[1] && !start_accepted[1])
    else $error("ignored hw frame trigger gave no event");
  a_hw_line_drop: assert property (hw_edge[2] && !wait_ff[2] |=> overtrigger_event[2] && !start_accepted[2])
    else $error("ignored hw line trigger gave no event");
  a_status_value: assert property (wait_status_select_ff == TWSM_SEL_LINE |-> wait_status_value == wait_ff[2])
    else $error("status value does not follow line wait");
  a_acq_wait_fall: assert property (accept[0] |=> !acq_start_wait_out && start_accepted[0])
    else $error("acquisition wait stayed high after accept");
  a_acq_wait_rise: assert property (!wait_ff[0] && acq_ready_in && hw_enable_ff[0] && !trig[0] |=> acq_start_wait_out)
    else $error("acquisition wait did not rise on entry");
  a_frame_wait_fall: assert property (accept[1] |=> !frame_start_wait_out ##1 (!frame_start_wait_out || $past(frame_ready_in)))
    else $error("frame wait stayed high after accept");
  a_frame_wait_rise: assert property (!wait_ff[1] && frame_ready_in && hw_enable_ff[1] && !trig[1] |=> frame_start_wait_out)
    else $error("frame wait did not rise on entry");
  a_acq_gate: assert property (!hw_enable_ff[0] |=> !acq_start_wait_out)
    else $error("acquisition wait shown without hw triggering");
  a_frame_gate: assert property (!hw_enable_ff[1] |=> !frame_start_wait_out)
    else $error("frame wait shown without hw triggering");
  a_line2_route: assert property (output_line_source_ff[1] == TWSM_SRC_FRAME_WAIT |=> out_line[1] == frame_start_wait_out)
    else $error("line 2 does not carry frame wait");
  a_line_wait: assert property (accept[2] |=> !line_start_wait_out && !wait_ff[2])
    else $error("line wait stayed high after accept");
  a_over_cause: assert property (overtrigger_event[2] |-> $past(trig[2]) && !$past(wait_ff[2]))
    else $error("line overtrigger pulse without an ignored trigger");
  a_frame_status: assert property (wait_status_select_ff == TWSM_SEL_FRAME |-> wait_status_value == wait_ff[1])
    else $error("status value does not follow frame wait");

  // an overtrigger pulse only follows an ignored trigger, and a frame trigger never has both outcomes
  a_acq_over_src: assert property (overtrigger_event[0] |-> $past(trig[0]) && !$past(wait_ff[0]))
    else $error("acquisition overtrigger pulse without an ignored trigger");
  a_frame_over_src: assert property (overtrigger_event[1] |-> $past(trig[1]) && !$past(wait_ff[1]))
    else $error("frame overtrigger pulse without an ignored trigger");
  a_one_outcome: assert property (!(start_accepted[1] && overtrigger_event[1]))
    else $error("frame trigger both accepted and ignored");

  // a dropped trigger always leaves a sticky mark, so software can still find it later
  a_acq_over_mark: assert property (over[0] |=> evt_status_ff[0])
    else $error("ignored acquisition trigger left no status mark");
  a_frame_over_mark: assert property (over[1] |=> evt_status_ff[1])
    else $error("ignored frame trigger left no status mark");
  a_line_over_mark: assert property (over[2] |=> evt_status_ff[2])
    else $error("ignored line trigger left no status mark");
  a_mark_sticky: assert property (evt_status_ff[2] && !evt_clear[2] |=> evt_status_ff[2])
    else $error("line overtrigger mark lost without a clear");
  // irq is registered from the old enable, so it lags an enable write by one cycle
  a_irq_level: assert property (irq == |(evt_status_ff & $past(evt_enable_ff)))
    else $error("irq does not follow enabled status");

  // line wait is never gated, and line 1 follows the line wait when that is its source
  a_line_wait_free: assert property (nxt_wait[2] |=> line_start_wait_out)
    else $error("line wait output hidden while waiting");
  a_line_wait_rise: assert property (!wait_ff[2] && line_ready_in |=> line_start_wait_out)
    else $error("line wait did not rise on entry");
  a_line1_route: assert property (output_line_source_ff[0] == TWSM_SRC_LINE_WAIT
    |=> out_line[0] == line_start_wait_out)
    else $error("line 1 does not carry the line wait");

  // main scenarios that the bench is expected to reach
  c_acq_accept: cover property (accept[0] ##[1:20] acq_ready_in);
  c_frame_over: cover property (hw_edge[1] && !wait_ff[1]);
  c_line_cycle: cover property (accept[2] ##[1:10] line_ready_in ##[1:10] accept[2]);
  c_irq_raise:  cover property ($rose(irq));
  c_sw_accept:  cover property (sw_trig_ff[0] && wait_ff[0]);

endmodule : twsm_monitor
`default_nettype wire

// ==== design/twsm_pkg.sv ====
// constants, register map and types for the trigger wait status monitor
`default_nettype none
package twsm_pkg;

  // register byte addresses, one aligned 32-bit word each
  localparam logic [7:0] TWSM_OFS_HW_ENABLE  = 8'h00;
  localparam logic [7:0] TWSM_OFS_SW_TRIGGER = 8'h04;
  localparam logic [7:0] TWSM_OFS_STAT_SEL   = 8'h08;
  localparam logic [7:0] TWSM_OFS_STAT_VALUE = 8'h0c;
  localparam logic [7:0] TWSM_OFS_LINE_PICK  = 8'h10;
  localparam logic [7:0] TWSM_OFS_LINE_SRC   = 8'h14;
  localparam logic [7:0] TWSM_OFS_EVT_STATUS = 8'h18;
  localparam logic [7:0] TWSM_OFS_EVT_ENABLE = 8'h1c;
  localparam logic [7:0] TWSM_OFS_EVT_CLEAR  = 8'h20;
  localparam logic [7:0] TWSM_OFS_WAIT_STATE = 8'h24;

  // bit position of each trigger type in every 3-bit field
  localparam int TWSM_BIT_ACQ   = 0;
  localparam int TWSM_BIT_FRAME = 1;
  localparam int TWSM_BIT_LINE  = 2;

  // values after reset
  localparam logic [2:0] TWSM_RST_WAIT      = 3'h1;
  localparam logic [2:0] TWSM_RST_HW_ENABLE = 3'h0;
  localparam logic [2:0] TWSM_RST_EVT_EN    = 3'h0;
  localparam logic       TWSM_RST_LINE_PICK = 1'h0;

  // number of physical output lines served here (line 1 and line 2)
  localparam int TWSM_NUM_LINES = 2;

  // status selector codes
  typedef enum logic [1:0] {
    TWSM_SEL_ACQ   = 2'h0,
    TWSM_SEL_FRAME = 2'h1,
    TWSM_SEL_LINE  = 2'h2
  } twsm_sel_t;

  // output line source codes
  typedef enum logic [1:0] {
    TWSM_SRC_LOW        = 2'h0,
    TWSM_SRC_ACQ_WAIT   = 2'h1,
    TWSM_SRC_FRAME_WAIT = 2'h2,
    TWSM_SRC_LINE_WAIT  = 2'h3
  } twsm_src_t;

  localparam twsm_src_t TWSM_RST_SRC_LINE1 = TWSM_SRC_LOW;
  localparam twsm_src_t TWSM_RST_SRC_LINE2 = TWSM_SRC_FRAME_WAIT;
  localparam twsm_sel_t TWSM_RST_STAT_SEL  = TWSM_SEL_ACQ;

endpackage : twsm_pkg
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the trigger wait status monitor
`default_nettype none
module tb
  import twsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, srst, hsel, hwrite, polite, rd_pend;
  logic [31:0] haddr, hwdata, lfsr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, go, kick;
  logic [4:0]  dly;
  wire  [31:0] hrdata;
  wire  [2:0]  wv, acc, ovt, trg, rdy;
  wire  [1:0]  out_line;
  wire         hreadyout, hresp, irq;
  logic [31:0] exp_rd[$];
  logic [31:0] exp_ev[$];
  int          errors, compares;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  twsm_monitor u_dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_acq_start_trigger_in(trg[0]), .ext_frame_start_trigger_in(trg[1]), .ext_line_start_trigger_in(trg[2]),
    .acq_ready_in(rdy[0]), .frame_ready_in(rdy[1]), .line_ready_in(rdy[2]), .acq_start_wait_out(wv[0]),
    .frame_start_wait_out(wv[1]), .line_start_wait_out(wv[2]), .out_line(out_line), .start_accepted(acc),
    .overtrigger_event(ovt), .irq(irq));

  twsm_far_model u_far (.clk(clk), .srst(srst), .go(go), .polite(polite), .dly(dly), .kick(kick),
    .wait_in(wv), .accepted(acc), .trig_out(trg), .ready_out(rdy));

  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_step

  task automatic finish_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  // hready only moves at rising edges, so its level at the falling edge is what the next edge samples
  task automatic bus_wait;
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) begin
      errors++;
      finish_test();
    end
    @(posedge clk);
  endtask : bus_wait

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    bus_wait();
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    @(posedge clk);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    bus_wait();
    htrans <= 2'h0;
    exp_rd.push_back(want);
    bus_wait();
  endtask : rd

  // waits until every noted event has been seen
  task automatic settle;
    int n;
    n = 0;
    while (exp_ev.size() != 0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      errors++;
      finish_test();
    end
    @(negedge clk);
  endtask : settle

  task automatic wait_hi(input int i);
    int n;
    n = 0;
    while (wv[i] !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    check({31'h0, wv[i]}, 32'h1, "wait re-entry");
    if (wv[i] !== 1'b1) finish_test();
  endtask : wait_hi

  task automatic fire(input int i, input logic pol);
    @(posedge clk);
    go     <= 3'h1 << i;
    polite <= pol;
    @(posedge clk);
    go     <= 3'h0;
  endtask : fire

  // result watcher: read data and event pulses are matched against the oldest note
  always @(posedge clk) begin
    if (srst) rd_pend = 1'b0;
    if (rd_pend && hreadyout) begin
      rd_pend = 1'b0;
      if (exp_rd.size() == 0) check(hrdata, 32'hdeadbeef, "stray read");
      else check(hrdata, exp_rd.pop_front(), "read data");
      check({31'h0, hresp}, 32'h0, "response okay");
    end
    if (hsel && hreadyout && htrans[1] && !hwrite) rd_pend = 1'b1;
    if ((acc | ovt) != 3'h0) begin
      if (exp_ev.size() == 0) check({26'h0, ovt, acc}, 32'h0, "stray event");
      else check({26'h0, ovt, acc}, exp_ev.pop_front(), "event");
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end

  initial begin
    srst = 1'b1; hsel = 1'b1; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    go = 3'h0; kick = 3'h0; polite = 1'b1; dly = 5'h10; lfsr = 32'h5a71; errors = 0; compares = 0; rd_pend = 1'b0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    // reset values; write-only and unmapped places read zero
    rd(TWSM_OFS_HW_ENABLE, 32'h0);
    rd(TWSM_OFS_SW_TRIGGER, 32'h0);
    rd(TWSM_OFS_WAIT_STATE, {29'h0, TWSM_RST_WAIT});
    rd(TWSM_OFS_EVT_ENABLE, 32'h0);
    rd(8'h3c, 32'h0);
    check({29'h0, wv}, 32'h0, "wait outs gated");
    for (int s = 0; s < 4; s++) begin
      wr(TWSM_OFS_STAT_SEL, 32'(s));
      rd(TWSM_OFS_STAT_VALUE, (s == 0) ? 32'h1 : 32'h0);
    end
    wr(TWSM_OFS_LINE_PICK, 32'h1);
    rd(TWSM_OFS_LINE_SRC, {30'h0, TWSM_RST_SRC_LINE2});
    wr(TWSM_OFS_LINE_PICK, 32'h0);
    rd(TWSM_OFS_LINE_SRC, {30'h0, TWSM_RST_SRC_LINE1});
    wr(TWSM_OFS_HW_ENABLE, 32'h7);
    kick <= 3'h6;
    @(posedge clk);
    kick <= 3'h0;
    wait_hi(0);
    wait_hi(1);
    wait_hi(2);
    check({30'h0, out_line}, 32'h2, "line 2 frame wait");
    // per type: accept, hardware and software overtrigger, event status, re-entry, software accept
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_step(lfsr);
      dly <= 5'h10 + {2'h0, lfsr[2:0]};
      wr(TWSM_OFS_EVT_ENABLE, (i == 2) ? 32'h3 : 32'h7);
      exp_ev.push_back(32'h1 << i);
      fire(i, 1'b1);
      settle();
      check({31'h0, wv[i]}, 32'h0, "wait drop");
      exp_ev.push_back(32'h8 << i);
      fire(i, 1'b0);
      settle();
      exp_ev.push_back(32'h8 << i);
      wr(TWSM_OFS_SW_TRIGGER, 32'h1 << i);
      settle();
      rd(TWSM_OFS_EVT_STATUS, 32'h1 << i);
      check({31'h0, irq}, (i != 2) ? 32'h1 : 32'h0, "irq mask");
      wr(TWSM_OFS_EVT_CLEAR, 32'h1 << i);
      rd(TWSM_OFS_EVT_STATUS, 32'h0);
      check({31'h0, irq}, 32'h0, "irq clear");
      wait_hi(i);
      exp_ev.push_back(32'h1 << i);
      wr(TWSM_OFS_SW_TRIGGER, 32'h1 << i);
      settle();
      wait_hi(i);
    end
    wr(TWSM_OFS_HW_ENABLE, 32'h5);
    repeat (2) @(negedge clk);
    check({29'h0, wv}, 32'h5, "frame wait gated");
    rd(TWSM_OFS_WAIT_STATE, 32'h7);
    // every source code on both lines: acq wait 1, frame wait 0 (gated), line wait 1
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        wr(TWSM_OFS_LINE_PICK, 32'(p));
        wr(TWSM_OFS_LINE_SRC, 32'(c));
        repeat (2) @(negedge clk);
        check({31'h0, out_line[p]}, (c == 1 || c == 3) ? 32'h1 : 32'h0, "routing");
      end
    end
    finish_test();
  end
endmodule : tb
`default_nettype wire

// ==== test/twsm_far_model.sv ====
// far side model: trigger source and acquisition engine restart pulses
`default_nettype none
module twsm_far_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [2:0] go,
  input  wire logic       polite,
  input  wire logic [4:0] dly,
  input  wire logic [2:0] kick,
  input  wire logic [2:0] wait_in,
  input  wire logic [2:0] accepted,
  output logic      [2:0] trig_out,
  output logic      [2:0] ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] pend_ff;
  logic [4:0] cnt_ff [3];

  // one-cycle trigger per request; polite mode holds it until the wait line is high
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_ff  <= 3'h0;
      trig_out <= 3'h0;
    end else begin
      trig_out <= pend_ff & ~trig_out & (wait_in | {3{~polite}});
      pend_ff  <= go | (pend_ff & ~trig_out);
    end
  end

  // restart pulse dly cycles after an accepted start; a slow engine keeps the wait low longer
  always_ff @(posedge clk) begin
    if (srst) begin
      ready_out <= 3'h0;
      for (int i = 0; i < 3; i++) cnt_ff[i] <= 5'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        ready_out[i] <= kick[i] || (cnt_ff[i] == 5'h1);
        cnt_ff[i]    <= accepted[i] ? dly : ((cnt_ff[i] != 5'h0) ? cnt_ff[i] - 5'h1 : 5'h0);
      end
    end
  end
endmodule : twsm_far_model
`default_nettype wire
